// ==== include/ctad_pkg.sv ====
`default_nettype none
package ctad_pkg;
   // ***************************************************
   // Operation and addressing codes
   // ***************************************************
   typedef enum logic [4:0] {
      OP_MOV, OP_PUSH, OP_POP, OP_ADD, OP_SUB, OP_ADD_WITH_CARRY,
      OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC, OP_POINTER_STEP_ADD,
      OP_POINTER_STEP_SUBTRACT, OP_DECIMAL_ADJUST_AFTER_ADD,
      OP_DECIMAL_ADJUST_AFTER_SUBTRACT, OP_UNSIGNED_MULTIPLY,
      OP_UNSIGNED_DIVIDE, OP_CMP, OP_NEG
   } ctad_op_t;
   typedef enum logic [2:0] {
      AM_REG, AM_IND, AM_DISP, AM_ABS8, AM_ABS16, AM_IMM, AM_PREDEC, AM_POSTINC
   } ctad_mode_t;
   typedef enum logic {FSM_IDLE, FSM_MEM} ctad_fsm_t;

   // ***************************************************
   // Constants
   // ***************************************************
   localparam logic [2:0] CTAD_SP = 3'h7;        // Stack pointer register index
   localparam logic [7:0] CTAD_ABS8_PAGE = 8'hFF; // Upper byte for short absolute
   localparam logic [15:0] CTAD_STEP_B = 16'h0001;
   localparam logic [15:0] CTAD_STEP_W = 16'h0002;
   localparam int CTAD_FLG_C = 0;
   localparam int CTAD_FLG_V = 1;
   localparam int CTAD_FLG_Z = 2;
   localparam int CTAD_FLG_N = 3;
   localparam int CTAD_FLG_H = 4;
   localparam logic [4:0] CTAD_CCR_RST = 5'h00;

   // ***************************************************
   // Whole datapath state
   // ***************************************************
   typedef struct packed {
      ctad_fsm_t st;
      logic [7:0][15:0] gpr; // General registers, 7 is the stack pointer
      logic [4:0] condition_flags_register;       // {H,N,Z,V,C}
      logic [15:0] addr;
      logic [15:0] wdata;
      logic we;
      logic word;
      logic [3:0] tgt;       // Load destination
      logic ptr_upd;         // Post-increment pending
      logic [2:0] ptr;
      logic [15:0] ptr_val;
      logic done;
      logic err;
   } ctad_dp_t;
   localparam ctad_dp_t CTAD_DP_RST = '0;
endpackage
`default_nettype wire

// ==== include/ctad_alu_if.sv ====
`default_nettype none
// Carrier between sequencing datapath and arithmetic unit
interface ctad_alu_if;
   import ctad_pkg::*;
   ctad_op_t op;
   logic word;
   logic c_in;
   logic h_in;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] res;
   logic [4:0] flags; // {H,N,Z,V,C}
   logic flags_we;
   logic res_we;
   modport dp (output op, word, c_in, h_in, a, b, input res, flags, flags_we, res_we);
   modport alu (input op, word, c_in, h_in, a, b, output res, flags, flags_we, res_we);
endinterface
`default_nettype wire

// ==== src/ctad_alu.sv ====
`default_nettype none
module ctad_alu
   import ctad_pkg::*;
(
   // Operands in, result out
   ctad_alu_if.alu bus
);
   // ***************************************************
   // Combinational arithmetic
   // ***************************************************
   always_comb begin
      logic [15:0] ax;
      logic [15:0] bx;
      logic [15:0] r;
      logic [16:0] s;
      logic [16:0] qt;
      logic [7:0] adj;
      logic sub;
      logic cin;
      logic cy;
      logic hc;
      logic ov;
      logic m;
      // Byte operands are zero-extended so bit 8 is carry or borrow
      ax = bus.word ? bus.a : {8'h00, bus.a[7:0]};
      bx = bus.word ? bus.b : {8'h00, bus.b[7:0]};
      r = 16'h0000;
      s = 17'h00000;
      qt = 17'h00000;
      adj = 8'h00;
      sub = 1'b0;
      cin = 1'b0;
      cy = 1'b0;
      hc = 1'b0;
      ov = 1'b0;
      m = 1'b0;
      bus.flags_we = 1'b1;
      bus.res_we = 1'b1;
      unique case (bus.op)
         OP_ADD, OP_ADD_WITH_CARRY, OP_INC, OP_SUB, OP_SUBTRACT_WITH_BORROW,
         OP_DEC, OP_CMP, OP_NEG: begin
            sub = bus.op inside {OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_DEC, OP_CMP, OP_NEG};
            cin = (bus.op inside {OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW}) & bus.c_in;
            if (bus.op inside {OP_INC, OP_DEC}) begin
               bx = 16'h0001;
            end
            s = sub ? {1'b0, ax} - {1'b0, bx} - {16'h0000, cin}
                    : {1'b0, ax} + {1'b0, bx} + {16'h0000, cin};
            r = s[15:0];
            cy = bus.word ? s[16] : s[8];
            hc = bus.word ? (ax[12] ^ bx[12] ^ s[12]) : (ax[4] ^ bx[4] ^ s[4]);
            m = bus.word ? r[15] : r[7];
            ov = bus.word ? ((ax[15] ^ bx[15] ^ ~sub) & (r[15] ^ ax[15]))
                          : ((ax[7] ^ bx[7] ^ ~sub) & (r[7] ^ ax[7]));
            bus.res_we = (bus.op != OP_CMP);
         end
         OP_POINTER_STEP_ADD, OP_POINTER_STEP_SUBTRACT: begin
            r = (bus.op == OP_POINTER_STEP_ADD) ? bus.a + bus.b : bus.a - bus.b;
            bus.flags_we = 1'b0;
         end
         OP_DECIMAL_ADJUST_AFTER_ADD: begin
            cy = bus.c_in | (bus.a[7:0] > 8'h99);
            adj = {1'b0, cy, cy, 1'b0, 1'b0, {2{bus.h_in | (bus.a[3:0] > 4'h9)}}, 1'b0};
            r = {8'h00, bus.a[7:0] + adj};
            m = r[7];
            hc = bus.h_in;
         end
         OP_DECIMAL_ADJUST_AFTER_SUBTRACT: begin
            adj = {1'b0, bus.c_in, bus.c_in, 1'b0, 1'b0, bus.h_in, bus.h_in, 1'b0};
            r = {8'h00, bus.a[7:0] - adj};
            cy = bus.c_in;
            m = r[7];
            hc = bus.h_in;
         end
         OP_UNSIGNED_MULTIPLY: begin
            r = 16'(bus.a[7:0] * bus.b[7:0]);
            m = r[15];
         end
         OP_UNSIGNED_DIVIDE: begin
            // Zero divisor or wide quotient leaves the register and sets V
            if (bus.b[7:0] == 8'h00) begin
               r = bus.a;
               ov = 1'b1;
            end else begin
               qt = {1'b0, bus.a / {8'h00, bus.b[7:0]}};
               ov = (qt[15:8] != 8'h00);
               r = ov ? bus.a : {8'(bus.a % {8'h00, bus.b[7:0]}), qt[7:0]};
            end
            m = r[7];
         end
         default: begin
            // Moves, push and pop end up here and write nothing
            bus.flags_we = 1'b0;
            bus.res_we = 1'b0;
         end
      endcase
      bus.res = r;
      bus.flags = {hc, m, (bus.word || bus.op == OP_UNSIGNED_MULTIPLY) ? (r == 16'h0000)
                   : (r[7:0] == 8'h00), ov, cy};
   end
endmodule
`default_nettype wire

// ==== src/ctad_datapath.sv ====
`default_nettype none
module ctad_datapath
   import ctad_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // Request from sequencer
   input wire logic op_valid_in,
   input wire ctad_op_t op_in,
   input wire logic word_in,
   input wire ctad_mode_t mode_in,
   input wire logic store_in,
   input wire logic [3:0] dst_in,
   input wire logic [3:0] src_in,
   input wire logic [2:0] ptr_in,
   input wire logic [15:0] imm_in,
   input wire logic step2_in,
   // Answer to sequencer
   output logic op_ready_out,
   output logic done_out,
   output logic error_out,
   // Data memory bus
   output logic mem_req_out,
   output logic mem_we_out,
   output logic mem_word_out,
   output logic [15:0] mem_addr_out,
   output logic [15:0] mem_wdata_out,
   input wire logic [15:0] mem_rdata_in,
   input wire logic mem_ack_in,
   // Register view
   input wire logic [2:0] view_sel_in,
   output logic [15:0] view_data_out,
   output logic [4:0] ccr_out
);
   // ***************************************************
   // Helpers
   // ***************************************************
   // Byte register: bit 3 picks low half, bits 2:0 the register
   function automatic logic [7:0] get_b(input logic [7:0][15:0] g, input logic [3:0] i);
      get_b = i[3] ? g[i[2:0]][7:0] : g[i[2:0]][15:8];
   endfunction

   function automatic logic [7:0][15:0] put_b(input logic [7:0][15:0] g,
                                              input logic [3:0] i, input logic [7:0] v);
      logic [7:0][15:0] o;
      o = g;
      if (i[3]) begin
         o[i[2:0]][7:0] = v;
      end else begin
         o[i[2:0]][15:8] = v;
      end
      put_b = o;
   endfunction

   function automatic logic bad_form(input ctad_op_t o, input logic w, input ctad_mode_t md);
      logic ri;
      ri = (md == AM_REG) || (md == AM_IMM);
      unique case (o)
         OP_MOV: bad_form = (md == AM_ABS8) && w;
         OP_ADD: bad_form = !ri || (w && md != AM_REG);
         OP_SUB: bad_form = (md != AM_REG);
         OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: bad_form = w || !ri;
         OP_CMP: bad_form = !ri || (w && md != AM_REG);
         OP_INC, OP_DEC, OP_NEG, OP_DECIMAL_ADJUST_AFTER_ADD,
         OP_DECIMAL_ADJUST_AFTER_SUBTRACT, OP_UNSIGNED_MULTIPLY,
         OP_UNSIGNED_DIVIDE: bad_form = w || (md != AM_REG);
         default: bad_form = 1'b0;
      endcase
   endfunction

   // ***************************************************
   // State
   // ***************************************************
   ctad_dp_t q;      // Registered state
   ctad_dp_t next_q; // Next state
   ctad_alu_if alu_bus();
   logic take;       // Request accepted this cycle
   logic is_mem;     // Request goes to memory
   logic wsz;        // Effective size of memory access
   logic [2:0] mptr; // Pointer register of memory access
   logic [15:0] base;
   logic [15:0] step;
   logic [15:0] ea;
   ctad_mode_t mmode;

   ctad_alu u_alu (
      .bus(alu_bus)
   );

   assign op_ready_out = (q.st == FSM_IDLE);
   assign take = op_valid_in && op_ready_out;
   assign done_out = q.done;
   assign error_out = q.err;
   assign mem_req_out = (q.st == FSM_MEM);
   assign mem_we_out = q.we;
   assign mem_word_out = q.word;
   assign mem_addr_out = q.addr;
   assign mem_wdata_out = q.wdata;
   assign view_data_out = q.gpr[view_sel_in];
   assign ccr_out = q.condition_flags_register;

   // ***************************************************
   // Effective address
   // ***************************************************
   always_comb begin
      is_mem = (op_in inside {OP_PUSH, OP_POP}) ||
               (op_in == OP_MOV && !(mode_in inside {AM_REG, AM_IMM}));
      wsz = (op_in inside {OP_PUSH, OP_POP}) ? 1'b1 : word_in;
      mptr = (op_in inside {OP_PUSH, OP_POP}) ? CTAD_SP : ptr_in;
      mmode = (op_in == OP_PUSH) ? AM_PREDEC : (op_in == OP_POP) ? AM_POSTINC : mode_in;
      base = q.gpr[mptr];
      step = wsz ? CTAD_STEP_W : CTAD_STEP_B;
      unique case (mmode)
         AM_DISP: ea = base + imm_in;
         AM_ABS8: ea = {CTAD_ABS8_PAGE, imm_in[7:0]};
         AM_ABS16: ea = imm_in;
         AM_PREDEC: ea = base - step;
         default: ea = base;
      endcase
      if (wsz) begin
         ea[0] = 1'b0;
      end
   end

   // ***************************************************
   // Arithmetic operand selection
   // ***************************************************
   always_comb begin
      alu_bus.op = op_in;
      alu_bus.word = word_in;
      alu_bus.c_in = q.condition_flags_register[CTAD_FLG_C];
      alu_bus.h_in = q.condition_flags_register[CTAD_FLG_H];
      if (op_in == OP_NEG) begin
         alu_bus.a = 16'h0000;
      end else if (word_in || op_in inside {OP_POINTER_STEP_ADD, OP_POINTER_STEP_SUBTRACT,
                   OP_UNSIGNED_MULTIPLY, OP_UNSIGNED_DIVIDE}) begin
         alu_bus.a = q.gpr[dst_in[2:0]];
         alu_bus.word = word_in || op_in inside {OP_POINTER_STEP_ADD, OP_POINTER_STEP_SUBTRACT};
      end else begin
         alu_bus.a = {8'h00, get_b(q.gpr, dst_in)};
      end
      if (op_in inside {OP_POINTER_STEP_ADD, OP_POINTER_STEP_SUBTRACT}) begin
         alu_bus.b = step2_in ? CTAD_STEP_W : CTAD_STEP_B;
      end else if (op_in == OP_NEG) begin
         alu_bus.b = {8'h00, get_b(q.gpr, dst_in)};
      end else if (mode_in == AM_IMM) begin
         alu_bus.b = word_in ? imm_in : {8'h00, imm_in[7:0]};
      end else if (word_in) begin
         alu_bus.b = q.gpr[src_in[2:0]];
      end else begin
         alu_bus.b = {8'h00, get_b(q.gpr, src_in)};
      end
   end

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      next_q.err = 1'b0;
      unique case (q.st)
         FSM_IDLE: begin
            if (take && bad_form(op_in, word_in, mode_in)) begin
               next_q.err = 1'b1;
            end else if (take && is_mem) begin
               next_q.st = FSM_MEM;
               next_q.addr = ea;
               next_q.word = wsz;
               next_q.we = (op_in == OP_PUSH) || (op_in == OP_MOV && store_in);
               next_q.wdata = wsz ? q.gpr[src_in[2:0]] : {8'h00, get_b(q.gpr, src_in)};
               next_q.tgt = dst_in;
               next_q.ptr = mptr;
               next_q.ptr_upd = (mmode == AM_POSTINC);
               next_q.ptr_val = base + step;
               if (mmode == AM_PREDEC) begin
                  next_q.gpr[mptr] = base - step;
               end
            end else if (take && op_in == OP_MOV) begin
               if (word_in) begin
                  next_q.gpr[dst_in[2:0]] = (mode_in == AM_IMM) ? imm_in : q.gpr[src_in[2:0]];
               end else begin
                  next_q.gpr = put_b(q.gpr, dst_in,
                                     (mode_in == AM_IMM) ? imm_in[7:0] : get_b(q.gpr, src_in));
               end
               next_q.done = 1'b1;
            end else if (take) begin
               if (alu_bus.res_we && alu_bus.word) begin
                  next_q.gpr[dst_in[2:0]] = alu_bus.res;
               end else if (alu_bus.res_we && op_in inside {OP_UNSIGNED_MULTIPLY,
                            OP_UNSIGNED_DIVIDE}) begin
                  next_q.gpr[dst_in[2:0]] = alu_bus.res;
               end else if (alu_bus.res_we) begin
                  next_q.gpr = put_b(q.gpr, dst_in, alu_bus.res[7:0]);
               end
               if (alu_bus.flags_we) begin
                  next_q.condition_flags_register = alu_bus.flags;
               end
               next_q.done = 1'b1;
            end
         end
         FSM_MEM: begin
            if (mem_ack_in) begin
               if (q.ptr_upd) begin
                  next_q.gpr[q.ptr] = q.ptr_val;
               end
               // Loaded data written last so it wins over the pointer
               if (!q.we && q.word) begin
                  next_q.gpr[q.tgt[2:0]] = mem_rdata_in;
               end else if (!q.we) begin
                  next_q.gpr = put_b(next_q.gpr, q.tgt, mem_rdata_in[7:0]);
               end
               next_q.ptr_upd = 1'b0;
               next_q.done = 1'b1;
               next_q.st = FSM_IDLE;
            end
         end
      endcase
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         q <= CTAD_DP_RST;
      end else begin
         q <= next_q;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   logic [15:0] sp_now; // Stack pointer as seen
   logic [15:0] mul_exp; // Product the request should give
   logic [127:0] gpr_all; // All registers for stability checks
   assign sp_now = q.gpr[CTAD_SP];
   assign mul_exp = 16'(q.gpr[dst_in[2:0]][7:0] * get_b(q.gpr, src_in));
   assign gpr_all = q.gpr;

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   a_abs8_top_page: assert property (
      take && op_in == OP_MOV && mode_in == AM_ABS8 && !word_in
      |=> mem_req_out && mem_addr_out[15:8] == 8'hFF) else $error("short page wrong");
   a_abs8_word_refused: assert property (
      take && op_in == OP_MOV && mode_in == AM_ABS8 && word_in
      |=> error_out && !mem_req_out) else $error("word short absolute taken");
   a_word_even_addr: assert property (
      mem_req_out && mem_word_out |-> !mem_addr_out[0]) else $error("odd word address");
   a_push_predec: assert property (
      take && op_in == OP_PUSH |=> mem_we_out && mem_word_out
      && sp_now == $past(sp_now) - 16'h0002 && mem_addr_out == {sp_now[15:1], 1'b0})
      else $error("push address wrong");
   a_pop_sp_hold: assert property (
      take && op_in == OP_POP |=> !mem_we_out && sp_now == $past(sp_now)
      && mem_addr_out == {sp_now[15:1], 1'b0}) else $error("pop moved pointer early");
   a_postinc_step: assert property (
      mem_req_out && mem_ack_in && q.ptr_upd && q.ptr == CTAD_SP && q.tgt[2:0] != CTAD_SP
      |=> done_out && sp_now == $past(mem_addr_out) + ($past(mem_word_out) ? 16'h0002
      : 16'h0001)) else $error("post-increment step wrong");
   a_mul_product: assert property (
      take && op_in == OP_UNSIGNED_MULTIPLY && !word_in && mode_in == AM_REG
      |=> done_out && q.gpr[$past(dst_in[2:0])] == $past(mul_exp))
      else $error("product wrong");
   a_cmp_no_write: assert property (
      take && op_in == OP_CMP |=> $stable(gpr_all)) else $error("compare wrote register");
   a_sub_imm_refused: assert property (
      take && op_in == OP_SUB && mode_in == AM_IMM |=> error_out ##1 op_ready_out)
      else $error("immediate subtract taken");

   c_push: cover property (take && op_in == OP_PUSH ##[1:8] done_out);
   c_pop: cover property (take && op_in == OP_POP ##[1:8] done_out);
   c_divide: cover property (take && op_in == OP_UNSIGNED_DIVIDE ##1 done_out);
   c_bcd_add: cover property (take && op_in == OP_DECIMAL_ADJUST_AFTER_ADD);
endmodule
`default_nettype wire

// ==== testbench/ctad_mem_model.sv ====
`default_nettype none
// ****
// Data memory on the far side of the bus
// ****
module ctad_mem_model (
   // Clock
   input wire logic clk_sys_in,
   // Access from the datapath
   input wire logic req_in,
   input wire logic we_in,
   input wire logic word_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   // Answer
   output logic [15:0] rdata_out,
   output logic ack_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535]; // Byte store, high byte first
   int stall_n; // Cycles the current access has waited
   // Answer after a random stall of zero to three cycles, so waits stay bounded
   initial begin
      ack_out = 1'b0;
      rdata_out = 16'h0000;
      stall_n = 0;
      forever begin
         @(posedge clk_sys_in);
         #1;
         // Bus not driven: pattern changes so stale data never matches
         rdata_out = ~rdata_out;
         if (ack_out) begin
            ack_out = 1'b0;
            stall_n = 0;
         end else if (req_in && (stall_n >= 3 || $urandom_range(2) == 0)) begin
            ack_out = 1'b1;
            if (we_in && word_in) begin
               mem[addr_in] = wdata_in[15:8];
               mem[addr_in + 16'h0001] = wdata_in[7:0];
            end else if (we_in) begin
               mem[addr_in] = wdata_in[7:0];
            end else if (word_in) begin
               rdata_out = {mem[addr_in], mem[addr_in + 16'h0001]};
            end else begin
               rdata_out = {~mem[addr_in], mem[addr_in]};
            end
         end else if (req_in) begin
            stall_n++;
         end
      end
   end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
`default_nettype none
`define CHK(nm, e, a) \
   begin \
      n_checks++; \
      if ((a) !== (e)) begin \
         error_cnt++; \
         $display("[FAIL] %s exp %h got %h", nm, e, a); \
      end \
   end
module tb;
   import ctad_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // Design ports
   logic clk_sys_in, nrst_in, op_valid_in, word_in, store_in, step2_in, mem_ack_in;
   ctad_op_t op_in;
   ctad_mode_t mode_in;
   logic [3:0] dst_in, src_in;
   logic [2:0] ptr_in, view_sel_in;
   logic [15:0] imm_in, mem_rdata_in, mem_addr_out, mem_wdata_out, view_data_out;
   logic op_ready_out, done_out, error_out, mem_req_out, mem_we_out, mem_word_out;
   logic [4:0] ccr_out;
   // Reference model state
   int error_cnt, n_checks;
   logic [15:0] rg [8];
   logic [3:0] ef; // Expected {N,Z,V,C}
   logic [15:0] last_a; // Last bus address
   logic err;
   ctad_op_t ops [7] = '{OP_ADD, OP_ADD, OP_SUB, OP_ADD_WITH_CARRY,
                         OP_SUBTRACT_WITH_BORROW, OP_CMP, OP_NEG};
   ctad_op_t rop [6] = '{OP_SUB, OP_ADD, OP_CMP, OP_INC, OP_MOV, OP_ADD_WITH_CARRY};
   ctad_mode_t rm [6] = '{AM_IMM, AM_IMM, AM_IMM, AM_REG, AM_ABS8, AM_REG};
   logic [5:0] rw = 6'h3E;
   ctad_datapath dut_u (.*);
   ctad_mem_model mem_u (.clk_sys_in(clk_sys_in), .req_in(mem_req_out), .we_in(mem_we_out),
      .word_in(mem_word_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   // Capture the address of each pending access
   always @(posedge clk_sys_in) begin
      if (mem_req_out === 1'b1) begin
         last_a <= mem_addr_out;
      end
   end
   // Byte add or subtract with flags
   function automatic logic [7:0] arith(logic [7:0] a, logic [7:0] b, logic c, logic s);
      logic [8:0] r;
      r = s ? {1'b0, a} - {1'b0, b} - 9'(c) : {1'b0, a} + {1'b0, b} + 9'(c);
      ef = {r[7], r[7:0] == 8'h00, ((a[7] ^ b[7]) == s) && (r[7] != a[7]), r[8]};
      return r[7:0];
   endfunction
   // One request; waits a bounded time for done or refusal
   task automatic run(input ctad_op_t o, input logic w, input ctad_mode_t m,
                      input logic [3:0] d, input logic [3:0] s, input logic [15:0] im);
      int k;
      `CHK("ready", 1'b1, op_ready_out)
      op_in = o;
      word_in = w;
      mode_in = m;
      dst_in = d;
      src_in = s;
      imm_in = im;
      op_valid_in = 1'b1;
      @(posedge clk_sys_in);
      #1;
      op_valid_in = 1'b0;
      for (k = 0; k < 30 && done_out !== 1'b1 && error_out !== 1'b1; k++) begin
         @(posedge clk_sys_in);
         #1;
      end
      err = error_out;
      `CHK("answer", 1'b1, k < 30)
      // Idle edge keeps valid from rising in the step it fell
      @(posedge clk_sys_in);
      #1;
   endtask
   // Compare every register, and the N, Z, V and C flags when known
   task automatic chk_all(input logic fl);
      for (int i = 0; i < 8; i++) begin
         view_sel_in = 3'(i);
         @(posedge clk_sys_in);
         #1;
         `CHK("reg", rg[i], view_data_out)
      end
      if (fl) `CHK("flags", ef, ccr_out[3:0])
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #(50 * 5000);
      error_cnt++;
      close_out();
   end
   initial begin
      logic [2:0] a, b;
      logic [7:0] x, y;
      logic c, s;
      int k;
      {op_valid_in, word_in, store_in, step2_in, nrst_in} = '0;
      op_in = OP_MOV;
      mode_in = AM_REG;
      {dst_in, src_in, ptr_in, view_sel_in, imm_in} = '0;
      k = $urandom(8449);
      repeat (10) @(posedge clk_sys_in);
      #1;
      nrst_in = 1'b1;
      rg = '{default: 16'h0000};
      ef = 4'h0;
      chk_all(1'b1);
      for (int i = 0; i < 8; i++) begin
         rg[i] = 16'($urandom);
         run(OP_MOV, 1'b1, AM_IMM, 4'(i), 4'h0, rg[i]);
      end
      // Wrap at the byte boundary
      rg[0][7:0] = 8'hFF;
      run(OP_MOV, 1'b0, AM_IMM, 4'h8, 4'h0, 16'h00FF);
      run(OP_INC, 1'b0, AM_REG, 4'h8, 4'h0, 16'h0000);
      rg[0][7:0] = 8'h00;
      chk_all(1'b0);
      run(OP_DEC, 1'b0, AM_REG, 4'h8, 4'h0, 16'h0000);
      rg[0][7:0] = 8'hFF;
      chk_all(1'b0);
      run(OP_MOV, 1'b0, AM_IMM, 4'h8, 4'h0, 16'h0009);
      run(OP_ADD, 1'b0, AM_IMM, 4'h8, 4'h0, 16'h0001);
      rg[0][7:0] = arith(8'h09, 8'h01, 1'b0, 1'b0);
      run(OP_DECIMAL_ADJUST_AFTER_ADD, 1'b0, AM_REG, 4'h8, 4'h0, 16'h0000);
      rg[0][7:0] = 8'h10;
      ef = 4'h0;
      chk_all(1'b1);
      // Borrow from the low digit, then adjust after subtract
      run(OP_SUBTRACT_WITH_BORROW, 1'b0, AM_IMM, 4'h8, 4'h0, 16'h0001);
      rg[0][7:0] = arith(8'h10, 8'h01, 1'b0, 1'b1);
      `CHK("half", 1'b1, ccr_out[4])
      run(OP_DECIMAL_ADJUST_AFTER_SUBTRACT, 1'b0, AM_REG, 4'h8, 4'h0, 16'h0000);
      rg[0][7:0] = 8'h09;
      ef = 4'h0;
      chk_all(1'b1);
      for (int t = 0; t < 28; t++) begin
         a = 3'($urandom_range(6));
         b = 3'($urandom_range(6));
         k = $urandom_range(6);
         x = rg[a][7:0];
         y = (k % 2 == 1) ? 8'($urandom) : rg[b][7:0];
         c = (k == 3 || k == 4) ? ef[0] : 1'b0;
         s = (k == 2 || k == 4 || k == 5 || k == 6);
         run(ops[k], 1'b0, (k % 2 == 1) ? AM_IMM : AM_REG, {1'b1, a}, {1'b1, b}, {8'h00, y});
         y = (k == 6) ? arith(8'h00, x, 1'b0, 1'b1) : arith(x, y, c, s);
         if (k != 5) rg[a][7:0] = y;
         chk_all(1'b1);
      end
      for (int t = 0; t < 4; t++) begin
         step2_in = t[0];
         run(t < 2 ? OP_POINTER_STEP_ADD : OP_POINTER_STEP_SUBTRACT, 1'b1, AM_REG,
             4'h5, 4'h0, 16'h0000);
         rg[5] = (t < 2) ? rg[5] + 16'(t[0] + 1) : rg[5] - 16'(t[0] + 1);
         chk_all(1'b1);
      end
      for (int t = 0; t < 6; t++) begin
         run(rop[t], rw[t], rm[t], 4'h9, 4'hA, 16'h0005);
         `CHK("refused", 1'b1, err)
         chk_all(1'b1);
      end
      run(OP_SUB, 1'b1, AM_REG, 4'h1, 4'h2, 16'h0000);
      rg[1] = rg[1] - rg[2];
      chk_all(1'b0);
      run(OP_UNSIGNED_MULTIPLY, 1'b0, AM_REG, 4'h4, 4'hB, 16'h0000);
      rg[4] = rg[4][7:0] * rg[3][7:0];
      ef = {rg[4][15], rg[4] == 16'h0000, 2'b00};
      chk_all(1'b1);
      x = 8'($urandom) | 8'h80;
      rg[4] = {1'b0, 15'($urandom)};
      run(OP_MOV, 1'b1, AM_IMM, 4'h4, 4'h0, rg[4]);
      run(OP_MOV, 1'b0, AM_IMM, 4'hB, 4'h0, {8'h00, x});
      rg[3][7:0] = x;
      run(OP_UNSIGNED_DIVIDE, 1'b0, AM_REG, 4'h4, 4'hB, 16'h0000);
      rg[4] = {8'(rg[4] % x), 8'(rg[4] / x)};
      ef = {rg[4][7], rg[4][7:0] == 8'h00, 2'b00};
      chk_all(1'b1);
      // Zero divisor leaves the register and sets V
      run(OP_MOV, 1'b0, AM_IMM, 4'hB, 4'h0, 16'h0000);
      rg[3][7:0] = 8'h00;
      run(OP_UNSIGNED_DIVIDE, 1'b0, AM_REG, 4'h4, 4'hB, 16'h0000);
      ef = {rg[4][7], rg[4][7:0] == 8'h00, 2'b10};
      chk_all(1'b1);
      // Stack traffic stays word sized
      // Stack pointer modes word only
      rg[7] = 16'h0100;
      run(OP_MOV, 1'b1, AM_IMM, 4'h7, 4'h0, 16'h0100);
      run(OP_PUSH, 1'b1, AM_REG, 4'h0, 4'h1, 16'h0000);
      rg[7] = 16'h00FE;
      `CHK("push addr", 16'h00FE, last_a)
      run(OP_POP, 1'b1, AM_REG, 4'h2, 4'h0, 16'h0000);
      rg[7] = 16'h0100;
      rg[2] = rg[1];
      chk_all(1'b0);
      store_in = 1'b1;
      run(OP_MOV, 1'b0, AM_ABS8, 4'h0, 4'h9, 16'h0034);
      `CHK("short addr", 16'hFF34, last_a)
      rg[3] = 16'hFF34;
      run(OP_MOV, 1'b1, AM_IMM, 4'h3, 4'h0, 16'hFF34);
      store_in = 1'b0;
      ptr_in = 3'h3;
      run(OP_MOV, 1'b0, AM_POSTINC, 4'hC, 4'h0, 16'h0000);
      rg[4][7:0] = rg[1][7:0];
      rg[3] = 16'hFF35;
      chk_all(1'b0);
      store_in = 1'b1;
      run(OP_MOV, 1'b1, AM_IND, 4'h0, 4'h1, 16'h0000);
      `CHK("odd word", 16'hFF34, last_a)
      run(OP_MOV, 1'b1, AM_PREDEC, 4'h0, 4'h1, 16'h0000);
      rg[3] = 16'hFF33;
      `CHK("pre dec", 16'hFF32, last_a)
      chk_all(1'b0);
      // Word load at an odd address reads the word stored through the pointer
      store_in = 1'b0;
      run(OP_MOV, 1'b1, AM_ABS16, 4'h6, 4'h0, 16'hFF35);
      rg[6] = rg[1];
      chk_all(1'b0);
      // Mid-run reset clears registers and flags
      nrst_in = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      nrst_in = 1'b1;
      rg = '{default: 16'h0000};
      ef = 4'h0;
      chk_all(1'b1);
      close_out();
   end
endmodule
`default_nettype wire
